// ### core/channel_interrupt_summary.sv
// Channel interrupt summary flags, one-second timer overflow status and interrupt output
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ns
`include "summary_params.svh"

module channel_interrupt_summary #(
	parameter int CHANNELS = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [CHANNELS-1:0] channel_pending,
	input wire logic timer_tick,
	input wire summary_pkg::reg_addr_type reg_addr,
	input wire summary_pkg::reg_byte_type reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output summary_pkg::reg_byte_type reg_rdata,
	output logic irq
);

	// ==========================================================
	// Channel summary flags
	// Pending lines come from on-chip logic on sys_clk, so no synchroniser
	// One flop per channel; a flag drops by itself one cycle after the
	// last source of its channel goes away, so software never clears it here
	logic [CHANNELS-1:0] summary_q;

	genvar ch;
	generate
		for (ch = 0; ch < CHANNELS; ch++) begin : g_summary
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					summary_q[ch] <= `RESET_FLAG;
				end else begin
					summary_q[ch] <= channel_pending[ch];
				end
			end

			flag_follow_a:
			assert property (@(posedge sys_clk) disable iff (rst) channel_pending[ch] |=> summary_q[ch])
				else $error("channel flag missed its pending source");

			flag_drop_a:
			assert property (@(posedge sys_clk) disable iff (rst) !channel_pending[ch] |=> !summary_q[ch])
				else $error("channel flag set with no pending source");
		end
	endgenerate

	// ==========================================================
	// Global configuration with the timer overflow mask
	summary_pkg::reg_byte_type global_configuration_q;
	logic timer_overflow_mask;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			global_configuration_q <= `RESET_CONFIGURATION;
		end else if (reg_wr && reg_addr == `ADDR_GLOBAL_CONFIGURATION) begin
			global_configuration_q <= reg_wdata;
		end
	end

	assign timer_overflow_mask = global_configuration_q[`TIMER_MASK_BIT];

	// ==========================================================
	// Timer overflow status, write one to clear
	logic timer_clear;
	logic [0:0] timer_overflow_status;

	assign timer_clear = reg_wr && reg_addr == `ADDR_TIMER_STATUS && reg_wdata[`TIMER_OVERFLOW_BIT];

	sticky_flags #(
		.WIDTH(1)
	) timer_flag (
		.sys_clk(sys_clk),
		.rst(rst),
		.set(timer_tick),
		.clear(timer_clear),
		.flag_q(timer_overflow_status)
	);

	// ==========================================================
	// Event status, clear and enable
	// Channel event fires when the first channel turns pending, so software
	// learns of new work without polling the summary registers
	summary_pkg::event_vector_type event_set;
	summary_pkg::event_vector_type event_clear;
	summary_pkg::event_vector_type event_status;
	summary_pkg::event_vector_type event_enable_q;

	always_comb begin
		event_set = `RESET_EVENTS;
		event_set[`EVENT_TIMER_BIT] = timer_tick;
		event_set[`EVENT_CHANNEL_BIT] = (|channel_pending) && !(|summary_q);
	end

	assign event_clear = (reg_wr && reg_addr == `ADDR_EVENT_CLEAR) ? reg_wdata[`EVENT_FIELD_MSB:0] : `RESET_EVENTS;

	sticky_flags #(
		.WIDTH(2)
	) event_flags (
		.sys_clk(sys_clk),
		.rst(rst),
		.set(event_set),
		.clear(event_clear),
		.flag_q(event_status)
	);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			event_enable_q <= `RESET_EVENTS;
		end else if (reg_wr && reg_addr == `ADDR_EVENT_ENABLE) begin
			event_enable_q <= reg_wdata[`EVENT_FIELD_MSB:0];
		end
	end

	// ==========================================================
	// Interrupt output
	// Overflow status drives the pin only while unmasked
	assign irq = (timer_overflow_status[0] && !timer_overflow_mask) || (|(event_status & event_enable_q));

	// ==========================================================
	// Read path, data valid only in the cycle after the strobe
	summary_pkg::reg_byte_type read_mux;

	always_comb begin
		read_mux = `RESET_BYTE;
		unique case (reg_addr)
			`ADDR_SUMMARY_LOW: read_mux = summary_q[`LOW_FIELD_MSB:`LOW_FIELD_LSB];
			`ADDR_SUMMARY_HIGH: read_mux = {1'b0, summary_q[`HIGH_FIELD_MSB:`HIGH_FIELD_LSB]};
			`ADDR_SUMMARY_ZERO: read_mux = {summary_q[`ZERO_CHANNEL_BIT], 7'h00};
			`ADDR_TIMER_STATUS: read_mux = {7'h00, timer_overflow_status};
			`ADDR_GLOBAL_CONFIGURATION: read_mux = global_configuration_q;
			`ADDR_EVENT_STATUS: read_mux = {6'h00, event_status};
			`ADDR_EVENT_ENABLE: read_mux = {6'h00, event_enable_q};
			default: read_mux = `RESET_BYTE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= `RESET_BYTE;
		end else if (reg_rd) begin
			reg_rdata <= read_mux;
		end else begin
			reg_rdata <= `RESET_BYTE;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	summary_high_a:
	assert property (reg_rd && reg_addr == `ADDR_SUMMARY_HIGH |=> reg_rdata == {1'b0, $past(summary_q[15:9])})
		else $error("high summary read wrong");

	flag_clear_a:
	assert property (!channel_pending[3] ##1 !channel_pending[3] |-> !summary_q[3])
		else $error("summary flag set with no pending source");

	flag_set_a:
	assert property (channel_pending != 16'h0000 |=> summary_q == $past(channel_pending) && summary_q != 16'h0000)
		else $error("summary flag missed pending source");

	zero_reg_a:
	assert property (reg_rd && reg_addr == `ADDR_SUMMARY_ZERO |=> reg_rdata == {$past(summary_q[0]), 7'h00})
		else $error("channel zero read wrong");

	timer_read_a:
	assert property (reg_rd && reg_addr == `ADDR_TIMER_STATUS |=> reg_rdata == {7'h00, $past(timer_overflow_status)})
		else $error("timer status read wrong");

	timer_clear_a:
	assert property (timer_clear && !timer_tick |=> !timer_overflow_status[0] ##1 (timer_overflow_status[0] == $past(timer_tick)))
		else $error("timer status not cleared");

	timer_irq_a:
	assert property (timer_tick && !(reg_wr && reg_addr == `ADDR_GLOBAL_CONFIGURATION) && !timer_overflow_mask
		|=> timer_overflow_status[0] && irq)
		else $error("overflow did not raise interrupt");

	summary_low_a:
	assert property (reg_rd && reg_addr == `ADDR_SUMMARY_LOW |=> reg_rdata == $past(summary_q[8:1]))
		else $error("low summary read wrong");

	idle_read_a:
	assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data outside read slot");

	// ==========================================================
	// Reset values
	// These must look through reset itself, so they switch the default disable off
	flags_reset_a:
	assert property (disable iff (1'b0) rst |=> summary_q == '0)
		else $error("summary flags not cleared by reset");

	timer_reset_a:
	assert property (disable iff (1'b0) rst |=> !timer_overflow_status[0])
		else $error("timer status not cleared by reset");

	irq_reset_a:
	assert property (disable iff (1'b0) rst |=> !irq)
		else $error("interrupt high after reset");

	rdata_reset_a:
	assert property (disable iff (1'b0) rst |=> reg_rdata == `RESET_BYTE)
		else $error("read data not cleared by reset");

	config_reset_a:
	assert property (disable iff (1'b0) rst
		|=> global_configuration_q == `RESET_CONFIGURATION && event_enable_q == `RESET_EVENTS)
		else $error("configuration not cleared by reset");

	// ==========================================================
	// Read path
	high_reserved_a:
	assert property (reg_rd && reg_addr == `ADDR_SUMMARY_HIGH |=> !reg_rdata[7])
		else $error("reserved bit of high summary set");

	zero_reserved_a:
	assert property (reg_rd && reg_addr == `ADDR_SUMMARY_ZERO |=> reg_rdata[6:0] == 7'h00)
		else $error("reserved bits of channel zero register set");

	timer_reserved_a:
	assert property (reg_rd && reg_addr == `ADDR_TIMER_STATUS |=> reg_rdata[7:1] == 7'h00)
		else $error("reserved bits of timer status set");

	unmapped_read_a:
	assert property (reg_rd && !(reg_addr inside {`ADDR_GLOBAL_CONFIGURATION, `ADDR_EVENT_STATUS,
		`ADDR_EVENT_ENABLE, `ADDR_SUMMARY_LOW, `ADDR_SUMMARY_HIGH, `ADDR_SUMMARY_ZERO, `ADDR_TIMER_STATUS})
		|=> reg_rdata == `RESET_BYTE)
		else $error("unmapped address returned data");

	config_read_a:
	assert property (reg_rd && reg_addr == `ADDR_GLOBAL_CONFIGURATION |=> reg_rdata == $past(global_configuration_q))
		else $error("configuration read wrong");

	event_read_a:
	assert property (reg_rd && reg_addr == `ADDR_EVENT_STATUS |=> reg_rdata == {6'h00, $past(event_status)})
		else $error("event status read wrong");

	enable_read_a:
	assert property (reg_rd && reg_addr == `ADDR_EVENT_ENABLE |=> reg_rdata == {6'h00, $past(event_enable_q)})
		else $error("event enable read wrong");

	clear_read_a:
	assert property (reg_rd && reg_addr == `ADDR_EVENT_CLEAR |=> reg_rdata == `RESET_BYTE)
		else $error("write-only clear register returned data");

	// ==========================================================
	// Timer overflow status and interrupt
	timer_hold_a:
	assert property (timer_overflow_status[0] && !timer_clear |=> timer_overflow_status[0])
		else $error("timer status dropped without a clear");

	timer_quiet_a:
	assert property (!timer_overflow_status[0] && !timer_tick |=> !timer_overflow_status[0])
		else $error("timer status set with no overflow");

	timer_wins_a:
	assert property (timer_tick && timer_clear |=> timer_overflow_status[0])
		else $error("overflow lost to a clear in the same cycle");

	timer_keep_a:
	assert property (reg_wr && reg_addr == `ADDR_TIMER_STATUS && !reg_wdata[`TIMER_OVERFLOW_BIT]
		&& timer_overflow_status[0] |=> timer_overflow_status[0])
		else $error("write of zero cleared timer status");

	irq_level_a:
	assert property (timer_overflow_status[0] && !timer_overflow_mask |-> irq)
		else $error("unmasked overflow status without interrupt");

	mask_gate_a:
	assert property (timer_overflow_mask && (event_status & event_enable_q) == '0 |-> !irq)
		else $error("masked overflow reached the interrupt");

	masked_set_a:
	assert property (timer_tick && timer_overflow_mask |=> timer_overflow_status[0])
		else $error("overflow not recorded while masked");

	timer_cause_a:
	assert property ($rose(timer_overflow_status[0]) |-> $past(timer_tick))
		else $error("timer status rose with no overflow");

	timer_drop_a:
	assert property (!$past(rst) && $fell(timer_overflow_status[0]) |-> $past(timer_clear))
		else $error("timer status fell with no write of one");

	irq_cause_a:
	assert property (irq |-> timer_overflow_status[0] || event_status != '0)
		else $error("interrupt with no status set");

	// ==========================================================
	// Configuration and enable writes
	config_write_a:
	assert property (reg_wr && reg_addr == `ADDR_GLOBAL_CONFIGURATION |=> global_configuration_q == $past(reg_wdata))
		else $error("configuration write lost");

	enable_write_a:
	assert property (reg_wr && reg_addr == `ADDR_EVENT_ENABLE
		|=> event_enable_q == $past(reg_wdata[`EVENT_FIELD_MSB:0]))
		else $error("event enable write lost");

	ro_write_a:
	assert property (reg_wr && reg_addr inside {`ADDR_SUMMARY_LOW, `ADDR_SUMMARY_HIGH, `ADDR_SUMMARY_ZERO}
		|=> $stable(global_configuration_q) && $stable(event_enable_q))
		else $error("write to a summary register changed state");

	summary_hold_a:
	assert property ($stable(channel_pending) |=> $stable(summary_q))
		else $error("summary flags moved with steady sources");

	// ==========================================================
	// Event flags
	channel_event_a:
	assert property ((|summary_q) && !$past(|summary_q) |-> event_status[`EVENT_CHANNEL_BIT])
		else $error("first pending channel not recorded as event");

	timer_event_a:
	assert property (timer_tick |=> event_status[`EVENT_TIMER_BIT])
		else $error("overflow not recorded as event");

	event_irq_a:
	assert property ((event_status & event_enable_q) != '0 |-> irq)
		else $error("enabled event without interrupt");

	// A set in the clearing cycle is allowed to win, so the clear check excludes it
	genvar ev;
	generate
		for (ev = 0; ev < $bits(summary_pkg::event_vector_type); ev++) begin : g_event_check
			event_clear_a:
			assert property (@(posedge sys_clk) disable iff (rst)
				event_clear[ev] && !event_set[ev] |=> !event_status[ev])
				else $error("event flag not cleared");

			event_hold_a:
			assert property (@(posedge sys_clk) disable iff (rst)
				event_status[ev] && !event_clear[ev] |=> event_status[ev])
				else $error("event flag dropped without clear");
		end
	endgenerate

endmodule : channel_interrupt_summary

// ### core/summary_params.svh
// Register offsets, field positions and reset values of the interrupt summary block
`ifndef SUMMARY_PARAMS_SVH
`define SUMMARY_PARAMS_SVH

// ==========================================================
// Register offsets
`define ADDR_GLOBAL_CONFIGURATION 10'h020
`define ADDR_EVENT_STATUS 10'h024
`define ADDR_EVENT_CLEAR 10'h028
`define ADDR_EVENT_ENABLE 10'h02C
`define ADDR_SUMMARY_LOW 10'h2C0
`define ADDR_SUMMARY_HIGH 10'h300
`define ADDR_SUMMARY_ZERO 10'h380
`define ADDR_TIMER_STATUS 10'h3C0

// ==========================================================
// Field positions
`define TIMER_OVERFLOW_BIT 0
`define TIMER_MASK_BIT 0
`define EVENT_TIMER_BIT 0
`define EVENT_CHANNEL_BIT 1
`define EVENT_FIELD_MSB 1
`define LOW_FIELD_MSB 8
`define LOW_FIELD_LSB 1
`define HIGH_FIELD_MSB 15
`define HIGH_FIELD_LSB 9
`define ZERO_CHANNEL_BIT 0

// ==========================================================
// Reset values
`define RESET_BYTE 8'h00
`define RESET_CONFIGURATION 8'h00
`define RESET_EVENTS 2'h0
`define RESET_CHANNELS 16'h0000
`define RESET_FLAG 1'b0

`endif

// ### core/summary_pkg.sv
// Types shared by the interrupt summary block
package summary_pkg;

	// ==========================================================
	// Register data and event vector types
	typedef logic [7:0] reg_byte_type;
	typedef logic [9:0] reg_addr_type;
	typedef logic [1:0] event_vector_type;

endpackage : summary_pkg

// ### core/sticky_flags.sv
// Bank of sticky flags where a set always beats a clear in the same cycle
`timescale 1ns/1ns

module sticky_flags #(
	parameter int WIDTH = 2
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] set,
	input wire logic [WIDTH-1:0] clear,
	output logic [WIDTH-1:0] flag_q
);

	// ==========================================================
	// One flip-flop per flag
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_flag
			always_ff @(posedge sys_clk) begin
				if (rst) begin
					flag_q[i] <= 1'b0;
				end else if (set[i]) begin
					flag_q[i] <= 1'b1;
				end else if (clear[i]) begin
					flag_q[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : sticky_flags

// ### verification/channel_interrupt_summary_tb_top.sv
// Testbench for the channel interrupt summary block
`timescale 1ns/1ns
`include "summary_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module channel_interrupt_summary_tb_top;
	// ==========================================================
	// Stimulus and observed signals
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [15:0] channel_pending = 16'h0000;
	logic timer_tick = 1'b0;
	summary_pkg::reg_addr_type reg_addr = 10'h000;
	summary_pkg::reg_byte_type reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	summary_pkg::reg_byte_type reg_rdata;
	logic irq;
	int checked = 0;
	int n_mismatch = 0;
	logic [15:0] p;

	always #4 sys_clk = ~sys_clk;

	channel_interrupt_summary #(.CHANNELS(16)) dut (.sys_clk(sys_clk), .rst(rst),
		.channel_pending(channel_pending), .timer_tick(timer_tick), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));

	// ==========================================================
	// Bus tasks
	task wr(input summary_pkg::reg_addr_type a, input summary_pkg::reg_byte_type d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are sampled there
	task rd(input summary_pkg::reg_addr_type a, input summary_pkg::reg_byte_type e);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd

	task tick();
		@(posedge sys_clk);
		timer_tick <= 1'b1;
		@(posedge sys_clk);
		timer_tick <= 1'b0;
		#1;
	endtask : tick

	task close_out();
		$display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	// ==========================================================
	// Test sequence
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`ADDR_SUMMARY_LOW, 8'h00);
		rd(`ADDR_SUMMARY_HIGH, 8'h00);
		rd(`ADDR_SUMMARY_ZERO, 8'h00);
		rd(`ADDR_TIMER_STATUS, 8'h00);
		rd(10'h3FF, 8'h00);
		`CHK(irq, 1'b0)
		$display("reset values done");
		// Walking one plus all ones catches swapped or shifted channel bits
		for (int i = 0; i <= 16; i++) begin
			p = (i == 16) ? 16'hFFFF : (16'h0001 << i);
			@(posedge sys_clk);
			channel_pending <= p;
			rd(`ADDR_SUMMARY_LOW, p[8:1]);
			rd(`ADDR_SUMMARY_HIGH, {1'b0, p[15:9]});
			rd(`ADDR_SUMMARY_ZERO, {p[0], 7'h00});
		end
		@(posedge sys_clk);
		channel_pending <= 16'h0000;
		wr(`ADDR_SUMMARY_HIGH, 8'hFF);
		wr(`ADDR_SUMMARY_ZERO, 8'hFF);
		rd(`ADDR_SUMMARY_HIGH, 8'h00);
		rd(`ADDR_SUMMARY_ZERO, 8'h00);
		$display("channel summary done");
		tick();
		`CHK(irq, 1'b1)
		rd(`ADDR_TIMER_STATUS, 8'h01);
		wr(`ADDR_TIMER_STATUS, 8'hFE);
		rd(`ADDR_TIMER_STATUS, 8'h01);
		wr(`ADDR_TIMER_STATUS, 8'h01);
		`CHK(irq, 1'b0)
		rd(`ADDR_TIMER_STATUS, 8'h00);
		// A tick in the clearing cycle must not be lost: both land on one edge
		@(posedge sys_clk);
		timer_tick <= 1'b1;
		reg_wr <= 1'b1;
		reg_addr <= `ADDR_TIMER_STATUS;
		reg_wdata <= 8'h01;
		@(posedge sys_clk);
		timer_tick <= 1'b0;
		reg_wr <= 1'b0;
		rd(`ADDR_TIMER_STATUS, 8'h01);
		wr(`ADDR_TIMER_STATUS, 8'h01);
		wr(`ADDR_GLOBAL_CONFIGURATION, 8'h01);
		rd(`ADDR_GLOBAL_CONFIGURATION, 8'h01);
		tick();
		`CHK(irq, 1'b0)
		rd(`ADDR_TIMER_STATUS, 8'h01);
		wr(`ADDR_GLOBAL_CONFIGURATION, 8'h00);
		`CHK(irq, 1'b1)
		wr(`ADDR_TIMER_STATUS, 8'h01);
		$display("timer status done");
		// Earlier ticks and channel activity left both event flags set
		wr(`ADDR_EVENT_CLEAR, 8'h03);
		rd(`ADDR_EVENT_STATUS, 8'h00);
		rd(`ADDR_EVENT_CLEAR, 8'h00);
		wr(`ADDR_EVENT_ENABLE, 8'h02);
		rd(`ADDR_EVENT_ENABLE, 8'h02);
		`CHK(irq, 1'b0)
		@(posedge sys_clk);
		channel_pending <= 16'h0004;
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(irq, 1'b1)
		rd(`ADDR_EVENT_STATUS, 8'h02);
		wr(`ADDR_EVENT_CLEAR, 8'h02);
		rd(`ADDR_EVENT_STATUS, 8'h00);
		`CHK(irq, 1'b0)
		$display("event interrupt done");
		close_out();
	end
endmodule : channel_interrupt_summary_tb_top
